// [common/port_seq_pkg.sv]
// Purpose: shared constants and types for the charge-port sequencer
// Assumes: 250 MHz core clock
// Notes: times kept in their own unit, counts derived from the rate
package port_seq_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ATTACH_MS = 150;
  localparam int DETACH_MS = 15;
  localparam int REVERSE_MS = 500;
  localparam int PERIOD_MAX_US = 40;
  localparam int EN_HIGH_LINE_NS = 250;
  localparam int EN_LOW_LINE_NS = 620;
  localparam int GATE_MIN_NS = 1000;
  localparam int DOVP_US = 3000;
  localparam int ATTACH_CYC = ATTACH_MS * 1000 * CLK_MHZ;
  localparam int DETACH_CYC = DETACH_MS * 1000 * CLK_MHZ;
  localparam int REVERSE_CYC = REVERSE_MS * 1000 * CLK_MHZ;
  localparam int PERIOD_CYC = PERIOD_MAX_US * CLK_MHZ;
  localparam int EN_H_CYC = (EN_HIGH_LINE_NS * CLK_MHZ + 999) / 1000;
  localparam int EN_L_CYC = (EN_LOW_LINE_NS * CLK_MHZ + 999) / 1000;
  localparam int GATE_MIN_CYC = (GATE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int DOVP_CYC = DOVP_US * CLK_MHZ;
  // register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_ATTACH = 5'h01;
  localparam logic [IRQ_W-1:0] IRQ_DETACH = 5'h02;
  localparam logic [IRQ_W-1:0] IRQ_REVERSE = 5'h04;
  localparam logic [IRQ_W-1:0] IRQ_DOVP = 5'h08;
  localparam logic [IRQ_W-1:0] IRQ_UVP = 5'h10;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ATTACHING = 2'b01,
    ST_ATTACHED = 2'b11,
    ST_DETACHING = 2'b10
  } port_state_e;

  typedef struct packed {
    logic load_switch;
    logic bleeder;
    logic bc_count;
    logic dl_275;
    logic req_5v;
  } port_out_s;
endpackage

// [hdl/charge_port_attach_sequencer.sv]
// Purpose: attach/detach sequencing, rectifier gating and protections
// Assumes: analog comparators arrive as async levels
// Notes: registers reached over APB, one interrupt level output
//
// How it works
// [R1] load switch on after 150 ms attach
// [R2] start charge detection counter with switch
// [R3] detach only after 15 ms continuous
// [R4] bleeder on whenever switch turns off
// [R5] restore 5 V request on detach
// [R6] 2.75 V data-line mode after enable
// [R7] leave 2.75 V mode when detection starts
// [R8] no 2.75 V return after protocol, until detach
// [R9] reverse mode after 500 ms no pulse
// [R10] flag pulse period beyond 40 us
// [R11] gate only after minimum high time
// [R12] gate held at least 1.0 us
// [R13] 3.0 ms data-line overvoltage, not in 2.75
// [R14] reduce-current variant lowers current limit
// [R15] pull-down variant pulls feedback, latches
// [R16] debounce restarts when condition drops
// [R17] variant choice is a static parameter
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module charge_port_attach_sequencer
  import port_seq_pkg::*;
#(
  parameter int ATTACH_N = ATTACH_CYC,
  parameter int DETACH_N = DETACH_CYC,
  parameter int REVERSE_N = REVERSE_CYC,
  parameter int PERIOD_N = PERIOD_CYC,
  parameter int DOVP_N = DOVP_CYC,
  parameter bit PULL_DOWN_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator inputs (asynchronous)
  input wire logic cc1_sink,
  input wire logic cc2_sink,
  input wire logic primary_pulse_sense,
  input wire logic high_line,
  input wire logic dl_ovp_cmp,
  input wire logic uvp_cmp,
  input wire logic protocol_hv,
  input wire logic vout_above_5v,
  // port controls
  output logic load_switch,
  output logic bleeder_pin,
  output logic bc_count_en,
  output logic dl_275_mode,
  output logic req_5v,
  output logic sync_rectifier_gate,
  output logic reverse_mode,
  output logic period_over,
  output logic dl_ovp_flag,
  output logic cc_reduce,
  output logic secondary_feedback_pin,
  output logic latch_mode,
  output logic irq
);
  localparam int NI = 8;
  localparam int CW = 32;
  logic [NI-1:0] s1, s2;
  logic [NI-1:0] raw;
  logic attach_in, pulse, hl, ovp_in, uvp_in, proto, above5;
  port_state_e state;
  port_out_s po;
  logic [CW-1:0] deb_cnt, rev_cnt, per_cnt, ovp_cnt, hi_cnt, gate_cnt;
  logic pulse_q, hv_seen, uvp_q, seq_enable;
  logic [IRQ_W-1:0] irq_stat, irq_mask, ev;
  logic [1:0] ctrl;
  logic wr, rd;

  assign raw = {vout_above_5v, protocol_hv, uvp_cmp, dl_ovp_cmp,
                high_line, primary_pulse_sense, cc2_sink, cc1_sink};
  // two-stage synchronisers, one per comparator
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
        end else begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
        end
      end
    end
  endgenerate
  assign attach_in = s2[0] | s2[1];
  assign pulse = s2[2];
  assign hl = s2[3];
  assign ovp_in = s2[4];
  assign uvp_in = s2[5];
  assign proto = s2[6];
  assign above5 = s2[7];
  assign seq_enable = ctrl[0];

  // attach / detach state machine
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      deb_cnt <= '0;
    end else if (!seq_enable) begin
      state <= ST_IDLE;
      deb_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          deb_cnt <= '0;
          if (attach_in) state <= ST_ATTACHING;
        end
        ST_ATTACHING: begin
          if (!attach_in) begin
            state <= ST_IDLE; // [R16]
            deb_cnt <= '0;
          end else if (deb_cnt >= CW'(ATTACH_N - 2)) begin
            state <= ST_ATTACHED; // [R1]
            deb_cnt <= '0;
          end else deb_cnt <= deb_cnt + 1'b1;
        end
        ST_ATTACHED: begin
          deb_cnt <= '0;
          if (!attach_in) state <= ST_DETACHING;
        end
        ST_DETACHING: begin
          if (attach_in) begin
            state <= ST_ATTACHED; // [R16]
            deb_cnt <= '0;
          end else if (deb_cnt >= CW'(DETACH_N - 2)) begin
            state <= ST_IDLE; // [R3]
            deb_cnt <= '0;
          end else deb_cnt <= deb_cnt + 1'b1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire sw_on = (state == ST_ATTACHED) || (state == ST_DETACHING);
  wire detach_ack = (state == ST_DETACHING) && !attach_in &&
                    (deb_cnt >= CW'(DETACH_N - 2));

  // protocol memory survives until a detach is acknowledged or the sequencer is disabled
  always_ff @(posedge mclk) begin
    if (!resetn) hv_seen <= 1'b0;
    else if (detach_ack || !seq_enable) hv_seen <= 1'b0; // [R8]
    else if (proto && sw_on) hv_seen <= 1'b1;
  end

  // port outputs; bleeder is the switch's complement while enabled, same edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      po <= '{load_switch: 1'b0, bleeder: 1'b0, bc_count: 1'b0,
              dl_275: 1'b0, req_5v: 1'b1};
    end else begin
      po.load_switch <= sw_on; // [R1]
      po.bc_count <= sw_on; // [R2]
      // a disable also opens the switch, so bleed on that edge too
      po.bleeder <= !sw_on && (seq_enable || po.load_switch); // [R4]
      // default 2.75 V until detection starts or protocol seen
      po.dl_275 <= seq_enable && !sw_on && !hv_seen; // [R6] [R7] [R8]
      if (detach_ack || !sw_on) po.req_5v <= 1'b1; // [R5]
      else if (above5) po.req_5v <= 1'b0;
    end
  end
  assign load_switch = po.load_switch;
  assign bleeder_pin = po.bleeder;
  assign bc_count_en = po.bc_count;
  assign dl_275_mode = po.dl_275;
  assign req_5v = po.req_5v;

  // primary pulse timing
  wire rise = pulse && !pulse_q;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pulse_q <= 1'b0;
      rev_cnt <= '0;
      per_cnt <= '0;
      reverse_mode <= 1'b0;
      period_over <= 1'b0;
    end else begin
      pulse_q <= pulse;
      if (pulse) begin
        rev_cnt <= '0; // [R16]
        reverse_mode <= 1'b0;
      end else if (rev_cnt >= CW'(REVERSE_N - 1)) reverse_mode <= 1'b1; // [R9]
      else rev_cnt <= rev_cnt + 1'b1;
      if (rise) begin
        per_cnt <= '0;
        period_over <= 1'b0;
      end else if (per_cnt >= CW'(PERIOD_N - 1)) period_over <= 1'b1; // [R10]
      else per_cnt <= per_cnt + 1'b1;
    end
  end

  // rectifier gate: qualify high time, then hold a minimum on-time
  wire [CW-1:0] en_need = hl ? CW'(EN_H_CYC) : CW'(EN_L_CYC);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hi_cnt <= '0;
      gate_cnt <= '0;
      sync_rectifier_gate <= 1'b0;
    end else begin
      if (!pulse) hi_cnt <= '0; // [R16]
      else if (hi_cnt < en_need) hi_cnt <= hi_cnt + 1'b1;
      if (!sync_rectifier_gate) begin
        gate_cnt <= '0;
        if (pulse && hi_cnt >= en_need && !reverse_mode && !uvp_q)
          sync_rectifier_gate <= 1'b1; // [R11]
      end else begin
        if (gate_cnt < CW'(GATE_MIN_CYC)) gate_cnt <= gate_cnt + 1'b1;
        if (gate_cnt >= CW'(GATE_MIN_CYC - 1) && pulse)
          sync_rectifier_gate <= 1'b0; // [R12]
      end
    end
  end

  // data-line over-voltage, ignored while 2.75 V mode is on
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ovp_cnt <= '0;
      dl_ovp_flag <= 1'b0;
    end else if (!ovp_in || po.dl_275) begin
      ovp_cnt <= '0; // [R13] [R16]
      dl_ovp_flag <= 1'b0;
    end else if (ovp_cnt >= CW'(DOVP_N - 1)) dl_ovp_flag <= 1'b1; // [R13]
    else ovp_cnt <= ovp_cnt + 1'b1;
  end

  // under-voltage response; variant is fixed at build time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      uvp_q <= 1'b0;
      cc_reduce <= 1'b0;
      secondary_feedback_pin <= 1'b0;
      latch_mode <= 1'b0;
    end else begin
      uvp_q <= uvp_in;
      if (!PULL_DOWN_VARIANT) cc_reduce <= uvp_in; // [R14] [R17]
      else if (uvp_in || latch_mode) begin
        secondary_feedback_pin <= 1'b1; // [R15] [R17]
        latch_mode <= 1'b1; // latch clears only by reset
      end
    end
  end

  // apb slave, zero wait state
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign ev = {uvp_in && !uvp_q, dl_ovp_flag == 1'b0 && ovp_in &&
               !po.dl_275 && ovp_cnt == CW'(DOVP_N - 1),
               !reverse_mode && !pulse && rev_cnt == CW'(REVERSE_N - 1),
               detach_ack, state == ST_ATTACHING && attach_in &&
               deb_cnt >= CW'(ATTACH_N - 2)};
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      irq_mask <= '0;
      irq_stat <= '0;
    end else begin
      if (wr && paddr == ADDR_CTRL) ctrl <= pwdata[1:0];
      if (wr && paddr == ADDR_IRQ_MASK) irq_mask <= pwdata[IRQ_W-1:0];
      // set wins over a write-one clear in the same cycle
      if (wr && paddr == ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | ev;
      else irq_stat <= irq_stat | ev;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      irq <= |(irq_stat & irq_mask);
      pslverr <= 1'b0;
      if (rd) begin
        case (paddr)
          ADDR_CTRL: prdata <= {30'h0, ctrl};
          ADDR_STATUS: prdata <= {22'h0, state, hv_seen, reverse_mode,
                                  sync_rectifier_gate, dl_ovp_flag,
                                  latch_mode, po.dl_275, po.load_switch,
                                  po.req_5v};
          ADDR_IRQ_STAT: prdata <= {27'h0, irq_stat};
          ADDR_IRQ_MASK: prdata <= {27'h0, irq_mask};
          default: begin
            prdata <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  a_bleed_tracks: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(load_switch) |-> bleeder_pin) // [R4]
    else $error("bleeder not on when switch fell");
  a_bc_with_sw: assert property (@(posedge mclk) disable iff (!resetn)
    bc_count_en == load_switch) // [R2]
    else $error("detection counter not tied to switch");
  a_attach_wait: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(load_switch) |-> $past(state, 2) == ST_ATTACHING) // [R1]
    else $error("switch on without attach debounce");
  a_no_275_on: assert property (@(posedge mclk) disable iff (!resetn)
    load_switch |-> !dl_275_mode) // [R7]
    else $error("2.75 V mode while detection runs");
  a_hv_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    hv_seen |=> !dl_275_mode) // [R8]
    else $error("2.75 V mode after protocol");
  a_ovp_ignore: assert property (@(posedge mclk) disable iff (!resetn)
    po.dl_275 |=> !dl_ovp_flag) // [R13]
    else $error("over-voltage flagged in 2.75 V mode");
  a_gate_min_on: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(sync_rectifier_gate) |-> sync_rectifier_gate [*3]) // [R12]
    else $error("gate on-time too short");
  a_gate_qual: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(sync_rectifier_gate) |-> $past(hi_cnt) >= $past(en_need)) // [R11]
    else $error("gate without minimum high time");
  a_req5_detach: assert property (@(posedge mclk) disable iff (!resetn)
    detach_ack |=> req_5v) // [R5]
    else $error("5 V request not restored");
  a_uvp_variant: assert property (@(posedge mclk) disable iff (!resetn)
    PULL_DOWN_VARIANT |-> !cc_reduce) // [R14]
    else $error("current reduced in pull-down variant");
  c_attach: cover property (@(posedge mclk) $rose(load_switch));
  c_detach: cover property (@(posedge mclk) detach_ack);
  c_gate: cover property (@(posedge mclk) $rose(sync_rectifier_gate));
  c_reverse: cover property (@(posedge mclk) $rose(reverse_mode));
endmodule

// [verif/port_device_model.sv]
// Purpose: portable device seen at the charging port
// Assumes: termination shows as a level on one channel pin
// Notes: protocol answer only while plugged, as a real sink
`timescale 1ns/1ps
module port_device_model (
  // bench control
  input wire logic mclk,
  input wire logic plug,
  input wire logic flip,
  input wire logic hv_req,
  // port pins
  output logic cc1_sink = 1'b0,
  output logic cc2_sink = 1'b0,
  output logic protocol_hv = 1'b0
);
  // unplugged device shows no termination on either pin
  always @(posedge mclk) begin
    cc1_sink <= plug & ~flip;
    cc2_sink <= plug & flip;
    protocol_hv <= plug & hv_req;
  end
endmodule

// [verif/charge_port_attach_sequencer_tb.sv]
// Purpose: self-checking bench for the charge-port sequencer
// Assumes: short debounce parameters, reduce-current and pull-down variants
// Notes: checks bracket each count except period and gate minimum on-time, sync delay left as margin
`timescale 1ns/1ps
module charge_port_attach_sequencer_tb;
  import port_seq_pkg::*;
  localparam int AN = 20;
  localparam int DN = 10;
  localparam int RN = 30;
  localparam int PN = 15;
  localparam int VN = 12;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic plug = 1'b0, flip = 1'b0, hv_req = 1'b0, pulse = 1'b0;
  logic hl = 1'b0, ovp = 1'b0, uvp = 1'b0, vhi = 1'b0;
  logic pulse_on = 1'b1;
  logic [2:0] ph = 3'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cc1, cc2, hv, a;
  logic ls, bleed, bc, dl, r5, gate, rev, po, dovp, ccr, fb_pull, lat, irq;
  logic pd_ccr, pd_fb, pd_lat;
  int n_errors = 0;
  int cmp_count = 0;

  always #2 mclk = ~mclk;
  // free pulse train, period 8 cycles, well inside the period limit
  always @(posedge mclk) if (pulse_on) begin
    ph <= ph + 3'h1;
    pulse <= (ph < 3'h2);
  end

  port_device_model sink (.mclk(mclk), .plug(plug), .flip(flip),
    .hv_req(hv_req), .cc1_sink(cc1), .cc2_sink(cc2), .protocol_hv(hv));
  charge_port_attach_sequencer #(.ATTACH_N(AN), .DETACH_N(DN),
    .REVERSE_N(RN), .PERIOD_N(PN), .DOVP_N(VN)) dut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cc1_sink(cc1), .cc2_sink(cc2),
    .primary_pulse_sense(pulse), .high_line(hl), .dl_ovp_cmp(ovp),
    .uvp_cmp(uvp), .protocol_hv(hv), .vout_above_5v(vhi),
    .load_switch(ls), .bleeder_pin(bleed), .bc_count_en(bc),
    .dl_275_mode(dl), .req_5v(r5), .sync_rectifier_gate(gate),
    .reverse_mode(rev), .period_over(po), .dl_ovp_flag(dovp),
    .cc_reduce(ccr), .secondary_feedback_pin(fb_pull), .latch_mode(lat),
    .irq(irq));
  // second build variant on the same pins, only its uvp outputs watched
  charge_port_attach_sequencer #(.ATTACH_N(AN), .DETACH_N(DN),
    .REVERSE_N(RN), .PERIOD_N(PN), .DOVP_N(VN),
    .PULL_DOWN_VARIANT(1'b1)) dut_pd (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .cc1_sink(cc1), .cc2_sink(cc2),
    .primary_pulse_sense(pulse), .high_line(hl), .dl_ovp_cmp(ovp),
    .uvp_cmp(uvp), .protocol_hv(hv), .vout_above_5v(vhi),
    .load_switch(), .bleeder_pin(), .bc_count_en(), .dl_275_mode(),
    .req_5v(), .sync_rectifier_gate(), .reverse_mode(),
    .period_over(), .dl_ovp_flag(), .cc_reduce(pd_ccr),
    .secondary_feedback_pin(pd_fb), .latch_mode(pd_lat), .irq());

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following setup never re-drives psel this step
    @(posedge mclk);
  endtask

  task automatic t_reset;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    chk("req_5v", 1, r5);
    chk("pd latch idle", 0, pd_lat);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
  endtask
  task automatic t_enable;
    apb(1'b1, ADDR_CTRL, 32'h1);
    cyc(4);
    chk("dl_275", 1, dl);
    ovp <= 1'b1;
    cyc(VN + 10);
    chk("dl_ovp in 2.75", 0, dovp);
    ovp <= 1'b0;
  endtask
  task automatic t_reverse;
    cyc(40);
    chk("period_over", 0, po);
    pulse_on <= 1'b0;
    cyc(1);
    pulse <= 1'b0;
    cyc(PN + 6);
    chk("period_over", 1, po);
    cyc(RN - PN - 10);
    chk("reverse early", 0, rev);
    cyc(10);
    chk("reverse", 1, rev);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq reverse", {27'h0, IRQ_REVERSE}, rd & 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    cyc(3);
    a = irq;
    apb(1'b1, ADDR_IRQ_MASK, 32'h1F);
    cyc(3);
    chk("irq masked", 0, a);
    chk("irq unmasked", 1, irq);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    cyc(3);
    chk("irq cleared", 0, irq);
  endtask
  task automatic t_gate;
    hl <= 1'b1;
    pulse <= 1'b1;
    cyc(55);
    chk("gate early hl", 0, gate);
    cyc(25);
    chk("gate hl", 1, gate);
    pulse <= 1'b0;
    cyc(100);
    chk("gate min on", 1, gate);
    hl <= 1'b0;
    cyc(300);
    pulse <= 1'b1;
    cyc(140);
    chk("gate early ll", 0, gate);
    cyc(30);
    chk("gate ll", 1, gate);
    pulse <= 1'b0;
  endtask
  // first termination dropped short of the count, then the other pin
  task automatic t_attach;
    plug <= 1'b1;
    cyc(AN - 5);
    plug <= 1'b0;
    cyc(5);
    flip <= 1'b1;
    plug <= 1'b1;
    cyc(AN - 3);
    chk("switch early", 0, ls);
    cyc(8);
    chk("switch", 1, ls);
    chk("bc count", 1, bc);
    chk("dl_275 left", 0, dl);
  endtask
  task automatic t_protect;
    vhi <= 1'b1;
    hv_req <= 1'b1;
    cyc(6);
    chk("dl_275 after hv", 0, dl);
    chk("req_5v raised", 0, r5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("hv seen", 32'h80, rd & 32'h80);
    ovp <= 1'b1;
    cyc(VN - 4);
    ovp <= 1'b0;
    cyc(2);
    ovp <= 1'b1;
    cyc(VN - 4);
    chk("dl_ovp early", 0, dovp);
    cyc(10);
    chk("dl_ovp", 1, dovp);
    ovp <= 1'b0;
    uvp <= 1'b1;
    cyc(20);
    chk("cc_reduce", 1, ccr);
    chk("feedback main", 0, fb_pull);
    chk("latch", 0, lat);
    chk("pd cc_reduce", 0, pd_ccr);
    chk("pd feedback", 1, pd_fb);
    chk("pd latch", 1, pd_lat);
    uvp <= 1'b0;
  endtask
  task automatic t_detach;
    plug <= 1'b0;
    cyc(DN - 4);
    chk("switch held", 1, ls);
    cyc(10);
    chk("switch off", 0, ls);
    chk("bleeder", 1, bleed);
    chk("req_5v back", 1, r5);
    chk("dl_275 back", 1, dl);
    chk("pd latch held", 1, pd_lat);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq attach detach", 32'h3, rd & 32'h3);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_enable();
    t_reverse();
    t_gate();
    t_attach();
    t_protect();
    t_detach();
    tally_and_finish();
  end
endmodule
